// >>> omsc_top.sv
// optical module status and control registers behind an axi4-lite slave
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module omsc_top
    import omsc_pkg::*;
(
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire logic [omsc_pkg::OMSC_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [omsc_pkg::OMSC_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    input  wire logic [omsc_pkg::OMSC_PORTS-1:0] fiber_mode,
    input  wire logic [omsc_pkg::OMSC_PORTS-1:0] loss_of_signal_inputs,
    input  wire logic [omsc_pkg::OMSC_PORTS-1:0] tx_fault_inputs,
    input  wire logic [omsc_pkg::OMSC_PORTS-1:0] module_present_inputs,
    output logic [omsc_pkg::OMSC_PORTS-1:0]      tx_disable,
    output logic [omsc_pkg::OMSC_PORTS-1:0]      two_wire_port_enable,
    output logic                             signal_loss_irq,
    output logic                             tx_fault_irq,
    output logic                             module_present_irq
);
    localparam int unsigned NP = OMSC_PORTS;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [3*NP-1:0] pins_s;
    logic [NP-1:0]   los_s;
    logic [NP-1:0]   fault_s;
    logic [NP-1:0]   present_s;

    omsc_sync #(.WIDTH(3*NP)) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in ({loss_of_signal_inputs, tx_fault_inputs, module_present_inputs}),
        .sync_out (pins_s)
    );

    // copper ports' pin levels are masked out; their tx_disable is not
    assign los_s     = pins_s[3*NP-1:2*NP] & fiber_mode;
    assign fault_s   = pins_s[2*NP-1:NP]   & fiber_mode;
    assign present_s = pins_s[NP-1:0]      & fiber_mode;

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    logic                   aw_held_q, aw_held_d;
    logic [OMSC_ADDR_W-1:0] awaddr_q, awaddr_d;
    logic                   w_held_q, w_held_d;
    logic [31:0]            wdata_q, wdata_d;
    logic [3:0]             wstrb_q, wstrb_d;
    logic                   bvalid_q, bvalid_d;
    logic [1:0]             bresp_q, bresp_d;
    logic                   wr_fire;
    logic                   wr_ctrl;
    logic [31:0]            byte_mask;

    assign s_axi_awready = !aw_held_q;
    assign s_axi_wready  = !w_held_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    // one write in flight: commit only once the previous response left
    assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
    assign wr_ctrl = wr_fire && (awaddr_q == OMSC_CONTROL_ADDR);

    always_comb begin
        aw_held_d = aw_held_q;
        awaddr_d  = awaddr_q;
        w_held_d  = w_held_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        if (s_axi_awvalid && !aw_held_q) begin
            aw_held_d = 1'b1;
            awaddr_d  = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held_q) begin
            w_held_d = 1'b1;
            wdata_d  = s_axi_wdata;
            wstrb_d  = s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (wr_fire) begin
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = (awaddr_q == OMSC_CONTROL_ADDR || awaddr_q == OMSC_STATUS_ADDR)
                        ? OMSC_RESP_OKAY : OMSC_RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            awaddr_q  <= '0;
            w_held_q  <= 1'b0;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= OMSC_RESP_OKAY;
        end else begin
            aw_held_q <= aw_held_d;
            awaddr_q  <= awaddr_d;
            w_held_q  <= w_held_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
        end
    end

    // ------------------------------------------------------------
    // control register and its outputs
    // ------------------------------------------------------------
    logic [31:0] ctrl_q, ctrl_d;
    logic [31:0] wr_mask;
    logic        los_irq_q, fault_irq_q, present_irq_q;
    logic        los_irq_d, fault_irq_d, present_irq_d;

    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++) begin : g_byte
            assign byte_mask[8*gb+7:8*gb] = {8{wstrb_q[gb]}};
        end
    endgenerate

    // status writes are accepted but store nothing; reserved bits stay zero
    assign wr_mask = byte_mask & OMSC_CONTROL_WMASK;

    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d = (ctrl_q & ~wr_mask) | (wdata_q & wr_mask);
        end
        los_irq_d     = ctrl_q[OMSC_LOS_EN_BIT] && (|los_s);
        fault_irq_d   = ctrl_q[OMSC_FAULT_EN_BIT] && (|fault_s);
        present_irq_d = ctrl_q[OMSC_PRESENT_EN_BIT] && (|present_s);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q        <= OMSC_CONTROL_RESET;
            los_irq_q     <= 1'b0;
            fault_irq_q   <= 1'b0;
            present_irq_q <= 1'b0;
        end else begin
            ctrl_q        <= ctrl_d;
            los_irq_q     <= los_irq_d;
            fault_irq_q   <= fault_irq_d;
            present_irq_q <= present_irq_d;
        end
    end

    assign tx_disable           = ctrl_q[OMSC_TX_DIS_LSB +: NP];
    // copper ports never get their management port
    assign two_wire_port_enable = ctrl_q[OMSC_TWP_EN_LSB +: NP] & fiber_mode;
    assign signal_loss_irq      = los_irq_q;
    assign tx_fault_irq         = fault_irq_q;
    assign module_present_irq   = present_irq_q;

    // ------------------------------------------------------------
    // status register and read channel
    // ------------------------------------------------------------
    logic [31:0] stat_q, stat_d;
    logic [31:0] stat_set;
    logic        rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0]  rresp_q, rresp_d;
    logic        rd_fire;
    logic        rd_stat;

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign rd_fire = s_axi_arvalid && !rvalid_q;
    assign rd_stat = rd_fire && (s_axi_araddr == OMSC_STATUS_ADDR);

    always_comb begin
        stat_set = 32'h0000_0000;
        stat_set[OMSC_LOS_LSB +: NP]     = los_s;
        stat_set[OMSC_FAULT_LSB +: NP]   = fault_s;
        stat_set[OMSC_PRESENT_LSB +: NP] = present_s;
        // a level seen in the read cycle survives the clear
        stat_d = (rd_stat ? 32'h0000_0000 : stat_q) | stat_set;
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (rd_fire) begin
            rvalid_d = 1'b1;
            rresp_d  = OMSC_RESP_OKAY;
            if (s_axi_araddr == OMSC_STATUS_ADDR) begin
                rdata_d = stat_q;
            end else if (s_axi_araddr == OMSC_CONTROL_ADDR) begin
                rdata_d = ctrl_q;
            end else begin
                rdata_d = 32'h0000_0000;
                rresp_d = OMSC_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_q   <= OMSC_STATUS_RESET;
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= OMSC_RESP_OKAY;
        end else begin
            stat_q   <= stat_d;
            rvalid_q <= rvalid_d;
            rdata_q  <= rdata_d;
            rresp_q  <= rresp_d;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence seq_ctrl_write;
        wr_ctrl && wstrb_q[0];
    endsequence

    sequence seq_stat_read_quiet;
        rd_stat && (stat_set == 32'h0000_0000);
    endsequence

    chk_los_capture: assert property (
        (|los_s) |=> ((stat_q[23:20] & $past(los_s)) == $past(los_s)))
        else $error("loss-of-signal level not captured in status");
    chk_fault_capture: assert property (
        (|fault_s) |=> ((stat_q[13:10] & $past(fault_s)) == $past(fault_s)))
        else $error("transmit-fault level not captured in status");
    chk_present_capture: assert property (
        (|present_s) |=> ((stat_q[3:0] & $past(present_s)) == $past(present_s)))
        else $error("module-present level not captured in status");
    chk_read_clears: assert property (
        seq_stat_read_quiet ##1 (stat_set == 32'h0000_0000) |->
            (stat_q == 32'h0000_0000) && s_axi_rvalid)
        else $error("status not cleared by read");
    chk_twp_reset: assert property (
        $rose(aresetn) |-> (ctrl_q[16:13] == 4'hF))
        else $error("two-wire port enables not set after reset");
    chk_los_irq: assert property (
        signal_loss_irq |-> ($past(ctrl_q[12]) && $past(|los_s)))
        else $error("loss-of-signal interrupt without cause");
    chk_fault_irq: assert property (
        $rose(tx_fault_irq) |-> ($past(ctrl_q[11]) && ($past(fault_s) != 4'h0)))
        else $error("transmit-fault interrupt without cause");
    chk_present_irq: assert property (
        (ctrl_q[10] && (|present_s)) |=> module_present_irq)
        else $error("module-present interrupt missing");
    chk_txdis_write: assert property (
        seq_ctrl_write |=> (tx_disable == $past(wdata_q[3:0])) && s_axi_bvalid)
        else $error("transmit-disable does not follow control write");
    chk_copper_mask: assert property (
        (two_wire_port_enable & ~fiber_mode) == 4'h0)
        else $error("management port enabled on copper port");
    // only a status read may drop a sticky bit
    chk_stat_sticky: assert property (
        !rd_stat |=> ((stat_q & $past(stat_q)) == $past(stat_q)))
        else $error("status bit lost without a read");
    chk_txdis_reset: assert property (
        $rose(aresetn) |-> (tx_disable == 4'h0))
        else $error("transmit-disable not zero after reset");
    chk_enables_reset: assert property (
        $rose(aresetn) |-> (ctrl_q[12:10] == 3'h0))
        else $error("interrupt enables not zero after reset");
endmodule // omsc_top
`default_nettype wire

// >>> omsc_pkg.sv
// constants shared by the optical module status and control block
package omsc_pkg;
    localparam int unsigned  OMSC_PORTS          = 4;
    localparam int unsigned  OMSC_ADDR_W         = 16;
    // printed register indices; byte address is four times the index
    localparam logic [15:0]  OMSC_STATUS_IDX     = 16'h0799;
    localparam logic [15:0]  OMSC_CONTROL_IDX    = 16'h079A;
    localparam logic [15:0]  OMSC_STATUS_ADDR    = 16'(OMSC_STATUS_IDX << 2);
    localparam logic [15:0]  OMSC_CONTROL_ADDR   = 16'(OMSC_CONTROL_IDX << 2);
    // status field positions (low bit of each four-bit field)
    localparam int unsigned  OMSC_LOS_LSB        = 20;
    localparam int unsigned  OMSC_FAULT_LSB      = 10;
    localparam int unsigned  OMSC_PRESENT_LSB    = 0;
    localparam logic [31:0]  OMSC_STATUS_RESET   = 32'h0000_0000;
    // control field positions
    localparam int unsigned  OMSC_TWP_EN_LSB     = 13;
    localparam int unsigned  OMSC_LOS_EN_BIT     = 12;
    localparam int unsigned  OMSC_FAULT_EN_BIT   = 11;
    localparam int unsigned  OMSC_PRESENT_EN_BIT = 10;
    localparam int unsigned  OMSC_TX_DIS_LSB     = 0;
    localparam logic [31:0]  OMSC_CONTROL_RESET  = 32'h0001_E000;
    localparam logic [31:0]  OMSC_CONTROL_WMASK  = 32'h0001_FC0F;
    // axi responses
    localparam logic [1:0]   OMSC_RESP_OKAY      = 2'h0;
    localparam logic [1:0]   OMSC_RESP_SLVERR    = 2'h2;
endpackage

// >>> omsc_sync.sv
// two-flop synchroniser for a vector of pin levels
`timescale 1ns/10ps
`default_nettype none
module omsc_sync #(
    parameter int unsigned WIDTH = 4
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule // omsc_sync
`default_nettype wire

// >>> omsc_optics_model.sv
// behavioural model of the four optical transceiver modules on the fiber ports
`timescale 1ns/10ps
`default_nettype none
module omsc_optics_model
    import omsc_pkg::*;
(
    input  wire logic [omsc_pkg::OMSC_PORTS-1:0] los_cmd,
    input  wire logic [omsc_pkg::OMSC_PORTS-1:0] fault_cmd,
    input  wire logic [omsc_pkg::OMSC_PORTS-1:0] present_cmd,
    output wire logic [omsc_pkg::OMSC_PORTS-1:0] loss_of_signal_inputs,
    output wire logic [omsc_pkg::OMSC_PORTS-1:0] tx_fault_inputs,
    output wire logic [omsc_pkg::OMSC_PORTS-1:0] module_present_inputs
);
    // ------------------------------------------------------------
    // pin levels
    // ------------------------------------------------------------
    // pins move on their own time, never on the sampling edge;
    // continuous drive also gives the idle level from 3 ns on
    assign #3 loss_of_signal_inputs = los_cmd;
    assign #3 tx_fault_inputs       = fault_cmd;
    assign #3 module_present_inputs = present_cmd;
endmodule // omsc_optics_model
`default_nettype wire

// >>> test_optical_module_status_control.sv
// self-checking bench for the optical module status and control registers
`timescale 1ns/10ps
`default_nettype none
module test_optical_module_status_control;
    import omsc_pkg::*;
    logic        aclk, aresetn;
    logic [15:0] awaddr, araddr;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb, fiber, los, flt, pres, los_p, flt_p, pres_p, txd, twp;
    logic [1:0]  bresp, rresp;
    logic [2:0]  irq;
    int          num_errors, samples_checked, k;
    omsc_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .fiber_mode(fiber), .loss_of_signal_inputs(los_p),
        .tx_fault_inputs(flt_p), .module_present_inputs(pres_p), .tx_disable(txd),
        .two_wire_port_enable(twp), .signal_loss_irq(irq[2]), .tx_fault_irq(irq[1]),
        .module_present_irq(irq[0]));
    omsc_optics_model i_optics (.los_cmd(los), .fault_cmd(flt), .present_cmd(pres),
        .loss_of_signal_inputs(los_p), .tx_fault_inputs(flt_p),
        .module_present_inputs(pres_p));
    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic hang(input string what);
        num_errors++;
        $display("BAD %s expected handshake seen none", what);
        end_of_test();
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // ------------------------------------------------------------
    // axi4-lite master
    // ------------------------------------------------------------
    // ready is sampled mid-cycle, where it is settled; the transfer is the next rising edge
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        int n;
        logic ta, tw, bv;
        logic [1:0] r;
        @(posedge aclk);
        awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= s; wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            bv = bvalid;
            r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (bv) begin
                bready <= 1'b0;
                chk("bresp", 32'(er), 32'(r));
                return;
            end
        end
        hang("write");
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] exp, input logic [1:0] er);
        int n;
        logic ta, rv;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(negedge aclk);
            ta = arvalid && arready;
            rv = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (rv) begin
                rready <= 1'b0;
                chk("rdata", exp, d);
                chk("rresp", 32'(er), 32'(r));
                return;
            end
        end
        hang("read");
    endtask
    // ------------------------------------------------------------
    // clock, reset and scenarios
    // ------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    initial begin
        aresetn = 1'b0; awaddr = '0; awvalid = 1'b0; wdata = '0; wstrb = '0; wvalid = 1'b0;
        bready = 1'b0; araddr = '0; arvalid = 1'b0; rready = 1'b0; fiber = 4'hF;
        los = 4'h0; flt = 4'h0; pres = 4'h0; num_errors = 0; samples_checked = 0;
        cyc(12);
        aresetn <= 1'b1;
        rd(OMSC_CONTROL_ADDR, 32'h0001_E000, OMSC_RESP_OKAY);
        rd(OMSC_STATUS_ADDR, 32'h0000_0000, OMSC_RESP_OKAY);
        chk("tx_disable", 32'h0, 32'(txd));
        chk("two_wire_en", 32'hF, 32'(twp));
        chk("irqs", 32'h0, 32'(irq));
        $display("test reset values done");
        // sticky levels survive the pins going away, then one read clears them
        los <= 4'h5; flt <= 4'hA; pres <= 4'h3;
        cyc(6);
        los <= 4'h0; flt <= 4'h0; pres <= 4'h0;
        cyc(6);
        rd(OMSC_STATUS_ADDR, 32'h0050_2803, OMSC_RESP_OKAY);
        rd(OMSC_STATUS_ADDR, 32'h0000_0000, OMSC_RESP_OKAY);
        $display("test status fields done");
        wr(OMSC_CONTROL_ADDR, 32'hFFFF_FFFF, 4'hF, OMSC_RESP_OKAY);
        rd(OMSC_CONTROL_ADDR, 32'h0001_FC0F, OMSC_RESP_OKAY);
        chk("tx_disable", 32'hF, 32'(txd));
        wr(OMSC_CONTROL_ADDR, 32'h0000_0005, 4'hF, OMSC_RESP_OKAY);
        chk("tx_disable", 32'h5, 32'(txd));
        chk("two_wire_en", 32'h0, 32'(twp));
        wr(OMSC_CONTROL_ADDR, 32'hFFFF_FFFF, 4'h2, OMSC_RESP_OKAY);
        rd(OMSC_CONTROL_ADDR, 32'h0000_FC05, OMSC_RESP_OKAY);
        wr(OMSC_STATUS_ADDR, 32'hFFFF_FFFF, 4'hF, OMSC_RESP_OKAY);
        rd(OMSC_STATUS_ADDR, 32'h0000_0000, OMSC_RESP_OKAY);
        wr(16'h1E60, 32'h0000_0001, 4'hF, OMSC_RESP_SLVERR);
        rd(16'h1E60, 32'h0000_0000, OMSC_RESP_SLVERR);
        $display("test control register done");
        // one source at a time: masked first, then enabled, then condition gone
        for (k = 0; k < 3; k++) begin
            wr(OMSC_CONTROL_ADDR, 32'h0, 4'hF, OMSC_RESP_OKAY);
            los <= (k == 0) ? 4'h4 : 4'h0;
            flt <= (k == 1) ? 4'h4 : 4'h0;
            pres <= (k == 2) ? 4'h4 : 4'h0;
            cyc(6);
            chk("irq masked", 32'h0, 32'(irq));
            wr(OMSC_CONTROL_ADDR, 32'h1 << (12 - k), 4'hF, OMSC_RESP_OKAY);
            cyc(4);
            chk("irq raised", 32'h4 >> k, 32'(irq));
            los <= 4'h0; flt <= 4'h0; pres <= 4'h0;
            cyc(6);
            chk("irq gone", 32'h0, 32'(irq));
            rd(OMSC_STATUS_ADDR, 32'h4 << (20 - 10 * k), OMSC_RESP_OKAY);
        end
        $display("test interrupt sources done");
        fiber <= 4'hE;
        wr(OMSC_CONTROL_ADDR, 32'h0001_F000, 4'hF, OMSC_RESP_OKAY);
        los <= 4'h1;
        cyc(6);
        chk("irq copper", 32'h0, 32'(irq));
        chk("two_wire_en", 32'hE, 32'(twp));
        rd(OMSC_STATUS_ADDR, 32'h0000_0000, OMSC_RESP_OKAY);
        $display("test copper port done");
        end_of_test();
    end
endmodule // test_optical_module_status_control
`default_nettype wire
